// ==== common/readout_pkg.sv ====
package readout_pkg;

  // ==========================================================================
  // Link addressing and packet layout
  // ==========================================================================
  localparam logic [6:0] DEV_ADDR = 7'h28;
  localparam int RESULT_W = 14;
  localparam int PACKET_BYTES = 4;
  localparam logic [1:0] STATUS_FRESH = 2'h0;
  localparam logic [1:0] STATUS_STALE = 2'h1;
  localparam logic [1:0] TEMP_PAD = 2'h0;
  localparam logic [1:0] RES_14BIT = 2'h3;

  // ==========================================================================
  // Timing, in ns and in sys_clk cycles
  // ==========================================================================
  localparam int CLK_NS = 10;
  localparam int I2C_QUARTER_NS = 2500;
  localparam int I2C_BUS_FREE_NS = 1000;
  localparam int SPI_HALF_NS = 625;
  localparam int SPI_HDSS_NS = 2500;
  localparam int SPI_SUSS_NS = 100;
  localparam int SPI_BUS_FREE_NS = 2000;
  localparam int I2C_QUARTER_CYC = (I2C_QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int I2C_BUS_FREE_CYC = (I2C_BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPI_HDSS_CYC = (SPI_HDSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPI_SUSS_CYC = (SPI_SUSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SPI_BUS_FREE_CYC = (SPI_BUS_FREE_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Host commands
  // ==========================================================================
  typedef enum logic [0:0] {
    CMD_FETCH = 1'h0,
    CMD_START = 1'h1
  } cmd_type;

  // Builds the four-byte packet: status and pressure, then temperature.
  function automatic logic [31:0] build_packet(input logic [1:0] status, input logic [13:0] p,
                                               input logic [13:0] t);
    build_packet = {status, p, t, TEMP_PAD};
  endfunction

endpackage

// ==== common/readout_if.sv ====
`timescale 1ns/10ps
interface readout_if;
  // I2C lines; the data line is open drain.
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;
  // SPI lines.
  logic sclk;
  logic ss_n;
  logic miso_out;
  logic miso_oe;
  logic miso;
  // Measurement ready pin.
  logic ready;

  // Open-drain level with pull-up, and the data-out wire pulled high when idle.
  assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));
  assign miso = miso_oe ? miso_out : 1'b1;

  modport device_end (
    input scl, sda, sclk, ss_n,
    output sda_dev_out, sda_dev_oe, miso_out, miso_oe, ready
  );
  modport host_end (
    output scl, sda_host_out, sda_host_oe, sclk, ss_n,
    input sda, miso, ready
  );
endinterface

// ==== src/host_readout_master.sv ====
`timescale 1ns/10ps
module host_readout_master
  import readout_pkg::*;
#(
  parameter int I2C_Q_CYC = I2C_QUARTER_CYC,
  parameter int SPI_H_CYC = SPI_HALF_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link to the device.
  readout_if.host_end link,
  // Command request.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_type cmd_kind,
  input wire logic use_spi,
  input wire logic spi_sample_rising,
  input wire logic [2:0] byte_count,
  // Read answers.
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic addr_nack,
  output logic ready_seen
);

  // Refuses phase counts that the 10-bit timer or the pin synchronisers cannot serve.
  if (I2C_Q_CYC < 8 || I2C_Q_CYC > 1023 || SPI_H_CYC < 8 || SPI_H_CYC > 1023) begin : g_bad_phase
    $error("Phase counts must lie in 8..1023.");
  end

  typedef enum logic [7:0] {
    H_IDLE = 8'h01,
    H_START = 8'h02,
    H_BIT = 8'h04,
    H_STOP = 8'h08,
    H_FREE = 8'h10,
    H_LEAD = 8'h20,
    H_SBIT = 8'h40,
    H_TAIL = 8'h80
  } host_state_type;

  typedef struct packed {
    host_state_type st;
    logic [9:0] tmr;
    logic [1:0] phase;
    logic [3:0] bit_i;
    logic [2:0] byte_i;
    logic [2:0] nbytes;
    logic [7:0] sh;
    logic rising;
    logic scl;
    logic sda_oe;
    logic sclk;
    logic ss_n;
    logic [1:0] sda_s;
    logic [1:0] miso_s;
    logic [1:0] rdy_s;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic nack;
  } host_regs_type;

  host_regs_type r_reg;
  host_regs_type r_next;
  logic tick;

  assign tick = (r_reg.tmr == 10'h000);

  // Sequences both protocols; every step after the command is taken waits for the phase timer.
  always_comb begin
    r_next = r_reg;
    r_next.rd_valid = 1'b0;
    r_next.done = 1'b0;
    r_next.sda_s = {r_reg.sda_s[0], link.sda};
    r_next.miso_s = {r_reg.miso_s[0], link.miso};
    r_next.rdy_s = {r_reg.rdy_s[0], link.ready};
    if (!tick) begin
      r_next.tmr = r_reg.tmr - 10'h001;
    end
    case (r_reg.st)
      H_IDLE: begin
        if (cmd_valid) begin
          r_next.byte_i = 3'h0;
          r_next.bit_i = 4'h0;
          r_next.phase = 2'h0;
          r_next.nack = 1'b0;
          r_next.rising = spi_sample_rising;
          if (use_spi) begin
            r_next.nbytes = (cmd_kind == CMD_FETCH) ? byte_count : 3'h1;
            r_next.ss_n = 1'b0;
            r_next.tmr = 10'(SPI_HDSS_CYC - 1);
            r_next.st = H_LEAD;
          end else begin
            r_next.nbytes = (cmd_kind == CMD_FETCH) ? byte_count : 3'h0;
            r_next.sh = {DEV_ADDR, cmd_kind == CMD_FETCH};
            r_next.sda_oe = 1'b1;
            r_next.tmr = 10'(I2C_Q_CYC - 1);
            r_next.st = H_START;
          end
        end
      end
      H_START: begin
        if (tick) begin
          r_next.scl = 1'b0;
          r_next.tmr = 10'(I2C_Q_CYC - 1);
          r_next.st = H_BIT;
        end
      end
      H_BIT: begin
        if (tick) begin
          r_next.tmr = 10'(I2C_Q_CYC - 1);
          r_next.phase = r_reg.phase + 2'h1;
          case (r_reg.phase)
            2'h0: begin
              if (r_reg.bit_i < 4'h8) begin
                r_next.sda_oe = (r_reg.byte_i == 3'h0) && !r_reg.sh[7];
              end else begin
                r_next.sda_oe = (r_reg.byte_i != 3'h0) && (r_reg.byte_i < r_reg.nbytes);
              end
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: begin
              r_next.sh = {r_reg.sh[6:0], r_reg.sda_s[1]};
              // The ninth bit is an acknowledge and must not shift into the byte.
              if (r_reg.bit_i == 4'h8) begin
                r_next.sh = r_reg.sh;
                if (r_reg.byte_i == 3'h0) begin
                  r_next.nack = r_reg.sda_s[1];
                end
              end
            end
            default: begin
              r_next.scl = 1'b0;
              r_next.bit_i = r_reg.bit_i + 4'h1;
              if (r_reg.bit_i == 4'h8) begin
                r_next.bit_i = 4'h0;
                r_next.byte_i = r_reg.byte_i + 3'h1;
                if (r_reg.byte_i != 3'h0) begin
                  r_next.rd_valid = 1'b1;
                  r_next.rd_data = (r_reg.byte_i == 3'h4) ? {r_reg.sh[7:2], 2'h0} : r_reg.sh;
                end
                if (r_reg.nack || r_reg.byte_i == r_reg.nbytes) begin
                  r_next.st = H_STOP;
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          r_next.tmr = 10'(I2C_Q_CYC - 1);
          r_next.phase = r_reg.phase + 2'h1;
          if (r_reg.phase == 2'h0) begin
            r_next.sda_oe = 1'b1;
          end else if (r_reg.phase == 2'h1) begin
            r_next.scl = 1'b1;
          end else begin
            r_next.sda_oe = 1'b0;
            r_next.tmr = 10'(I2C_BUS_FREE_CYC - 1);
            r_next.st = H_FREE;
          end
        end
      end
      H_LEAD: begin
        if (tick) begin
          r_next.tmr = 10'(SPI_H_CYC - 1);
          r_next.st = H_SBIT;
        end
      end
      H_SBIT: begin
        if (tick) begin
          r_next.tmr = 10'(SPI_H_CYC - 1);
          r_next.sclk = !r_reg.sclk;
          // Samples while making the chosen edge: a fall starts from high, a rise from low.
          if (r_reg.sclk != r_reg.rising) begin
            r_next.sh = {r_reg.sh[6:0], r_reg.miso_s[1]};
          end
          if (r_reg.sclk) begin
            r_next.bit_i = r_reg.bit_i + 4'h1;
            if (r_reg.bit_i == 4'h7) begin
              r_next.bit_i = 4'h0;
              r_next.byte_i = r_reg.byte_i + 3'h1;
              r_next.rd_valid = 1'b1;
              r_next.rd_data = r_reg.rising ? r_reg.sh : {r_reg.sh[6:0], r_reg.miso_s[1]};
              if (r_reg.byte_i == 3'h3) begin
                r_next.rd_data[1:0] = 2'h0;
              end
              if (r_reg.byte_i + 3'h1 == r_reg.nbytes) begin
                r_next.tmr = 10'(SPI_SUSS_CYC - 1);
                r_next.st = H_TAIL;
              end
            end
          end
        end
      end
      H_TAIL: begin
        if (tick) begin
          r_next.ss_n = 1'b1;
          r_next.tmr = 10'(SPI_BUS_FREE_CYC - 1);
          r_next.st = H_FREE;
        end
      end
      H_FREE: begin
        if (tick) begin
          r_next.done = 1'b1;
          r_next.st = H_IDLE;
        end
      end
      default: r_next.st = H_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg <= '{st: H_IDLE, scl: 1'b1, ss_n: 1'b1, sda_s: 2'h3, miso_s: 2'h3, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs.
  assign cmd_ready = (r_reg.st == H_IDLE);
  assign link.scl = r_reg.scl;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = r_reg.sda_oe;
  assign link.sclk = r_reg.sclk;
  assign link.ss_n = r_reg.ss_n;
  assign rd_data = r_reg.rd_data;
  assign rd_valid = r_reg.rd_valid;
  assign done = r_reg.done;
  assign addr_nack = r_reg.nack;
  assign ready_seen = r_reg.rdy_s[1];

endmodule // host_readout_master

// ==== src/sensor_readout_device.sv ====
`timescale 1ns/10ps
// Operation
// - SPI is read-only, half-duplex, up to 800kHz.
// - Option picks master sampling edge for data-out.
// - Default: master samples data-out on falling edge.
// - Result fetch works over I2C and SPI.
// - Measurement start works over I2C and SPI.
// - Load packet at address or slave-select fall.
// - Output register frozen during a transfer.
// - Results always scaled to 14 bits.
// - Most significant byte and bit first.
// - Host sends address with read bit one.
// - Acknowledge own read address, then send bytes.
// - Send until master not-acknowledges and stops.
// - Status in two top bits of pressure.
// - Status 00 when results not yet read.
// - Status 01 when already read; never 1x.
// - Temperature follows: high eight, then low six.
// - Last two temperature bits undefined; host masks.
// - Read may end after first temperature byte.
// - Read may end after second pressure byte.
// - Answer only I2C address 0x28.
// - Ready held high until a fetch arrives.
// - SPI packet is four bytes, status first.
// - Host starts measurement with address write, stop.
module sensor_readout_device
  import readout_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link to the host.
  readout_if.device_end link,
  // Configuration levels.
  input wire logic spi_mode,
  input wire logic spi_sample_rising,
  input wire logic sleep_mode,
  // Measurement results.
  input wire logic meas_done,
  input wire logic [1:0] meas_res,
  input wire logic [13:0] pressure_raw,
  input wire logic [13:0] temperature_raw,
  // Command events.
  output logic fetch_results_cmd,
  output logic start_conversion_cmd
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [4:0] {
    I_IDLE = 5'h01,
    I_ADDR = 5'h02,
    I_AACK = 5'h04,
    I_TX = 5'h08,
    I_MACK = 5'h10
  } i2c_state_type;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] sclk_s;
    logic [2:0] ss_s;
    i2c_state_type st;
    logic [3:0] cnt;
    logic [7:0] addr_sh;
    logic [31:0] sh;
    logic sda_low;
    logic mack;
    logic spi_act;
    logic spi_pend;
    logic ready;
    logic stale;
    logic [13:0] p_hold;
    logic [13:0] t_hold;
    logic fetch;
    logic start;
  } dev_regs_type;

  dev_regs_type r_reg;
  dev_regs_type r_next;
  logic scl_rise;
  logic scl_fall;
  logic i2c_start;
  logic i2c_stop;
  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;
  logic [31:0] packet;

  // Scales a result of any resolution to the full 14-bit range.
  function automatic logic [13:0] scale14(input logic [1:0] res, input logic [13:0] raw);
    scale14 = raw << (6'(RES_14BIT - res) * 6'h2);
  endfunction

  // ==========================================================================
  // Edge and condition detection on synchronised pins
  // ==========================================================================
  // Bit 0 is the first stage, bit 1 the synchronised level, bit 2 its last value.
  assign scl_rise = r_reg.scl_s[1] & ~r_reg.scl_s[2];
  assign scl_fall = ~r_reg.scl_s[1] & r_reg.scl_s[2];
  assign i2c_start = r_reg.scl_s[1] & r_reg.scl_s[2] & r_reg.sda_s[2] & ~r_reg.sda_s[1];
  assign i2c_stop = r_reg.scl_s[1] & r_reg.scl_s[2] & ~r_reg.sda_s[2] & r_reg.sda_s[1];
  assign sclk_rise = r_reg.sclk_s[1] & ~r_reg.sclk_s[2];
  assign sclk_fall = ~r_reg.sclk_s[1] & r_reg.sclk_s[2];
  assign ss_fall = ~r_reg.ss_s[1] & r_reg.ss_s[2];
  assign ss_rise = r_reg.ss_s[1] & ~r_reg.ss_s[2];
  assign packet = build_packet(r_reg.stale ? STATUS_STALE : STATUS_FRESH,
                               r_reg.p_hold, r_reg.t_hold);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // Runs the I2C slave or the SPI slave, then books reads and new results.
  always_comb begin
    r_next = r_reg;
    r_next.fetch = 1'b0;
    r_next.start = 1'b0;
    r_next.scl_s = {r_reg.scl_s[1:0], link.scl};
    r_next.sda_s = {r_reg.sda_s[1:0], link.sda};
    r_next.sclk_s = {r_reg.sclk_s[1:0], link.sclk};
    r_next.ss_s = {r_reg.ss_s[1:0], link.ss_n};
    if (!spi_mode) begin
      r_next.spi_act = 1'b0;
      if (i2c_stop) begin
        r_next.st = I_IDLE;
        r_next.sda_low = 1'b0;
      end else if (i2c_start) begin
        r_next.st = I_ADDR;
        r_next.cnt = 4'h0;
        r_next.sda_low = 1'b0;
      end else begin
        case (r_reg.st)
          I_IDLE: r_next.sda_low = 1'b0;
          I_ADDR: begin
            if (scl_rise) begin
              r_next.addr_sh = {r_reg.addr_sh[6:0], r_reg.sda_s[1]};
              r_next.cnt = r_reg.cnt + 4'h1;
            end else if (scl_fall && r_reg.cnt == 4'h8) begin
              if (r_reg.addr_sh[7:1] == DEV_ADDR) begin
                r_next.sda_low = 1'b1;
                r_next.st = I_AACK;
              end else begin
                r_next.st = I_IDLE;
              end
            end
          end
          I_AACK: begin
            if (scl_fall) begin
              if (r_reg.addr_sh[0]) begin
                r_next.sh = packet;
                r_next.sda_low = !packet[31];
                r_next.cnt = 4'h0;
                r_next.st = I_TX;
                r_next.fetch = !sleep_mode;
                r_next.start = sleep_mode;
              end else begin
                r_next.sda_low = 1'b0;
                r_next.st = I_IDLE;
                r_next.start = 1'b1;
              end
            end
          end
          I_TX: begin
            if (scl_rise) begin
              r_next.cnt = r_reg.cnt + 4'h1;
            end else if (scl_fall) begin
              // Past the fourth byte the register shifts out ones.
              r_next.sh = {r_reg.sh[30:0], 1'b1};
              if (r_reg.cnt == 4'h8) begin
                r_next.sda_low = 1'b0;
                r_next.st = I_MACK;
              end else begin
                r_next.sda_low = !r_reg.sh[30];
              end
            end
          end
          I_MACK: begin
            if (scl_rise) begin
              r_next.mack = !r_reg.sda_s[1];
            end else if (scl_fall) begin
              if (r_reg.mack) begin
                r_next.st = I_TX;
                r_next.cnt = 4'h0;
                r_next.sda_low = !r_reg.sh[31];
              end else begin
                r_next.st = I_IDLE;
              end
            end
          end
          default: r_next.st = I_IDLE;
        endcase
      end
    end else begin
      // SPI: nothing is taken from the master, data only goes out.
      r_next.st = I_IDLE;
      r_next.sda_low = 1'b0;
      if (ss_fall) begin
        r_next.spi_act = 1'b1;
        r_next.sh = packet;
        r_next.spi_pend = 1'b0;
        r_next.fetch = !sleep_mode;
        r_next.start = sleep_mode;
      end else if (ss_rise) begin
        r_next.spi_act = 1'b0;
      end else if (r_reg.spi_act) begin
        // A change edge shifts only once the master has sampled the bit.
        if (spi_sample_rising ? sclk_rise : sclk_fall) begin
          r_next.spi_pend = 1'b1;
        end else if ((spi_sample_rising ? sclk_fall : sclk_rise) && r_reg.spi_pend) begin
          r_next.sh = {r_reg.sh[30:0], 1'b1};
          r_next.spi_pend = 1'b0;
        end
      end
    end
    // A fetch marks results stale and drops ready; a new result overrides.
    if (r_next.fetch) begin
      r_next.ready = 1'b0;
      r_next.stale = 1'b1;
    end
    // New results land in the holding register only; the shift register keeps its copy.
    if (meas_done) begin
      r_next.p_hold = scale14(meas_res, pressure_raw);
      r_next.t_hold = scale14(meas_res, temperature_raw);
      r_next.ready = 1'b1;
      r_next.stale = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg <= '{st: I_IDLE, scl_s: 3'h7, sda_s: 3'h7, ss_s: 3'h7, sh: 32'hFFFFFFFF, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = r_reg.sda_low;
  assign link.miso_out = r_reg.sh[31];
  assign link.miso_oe = r_reg.spi_act;
  assign link.ready = r_reg.ready;
  assign fetch_results_cmd = r_reg.fetch;
  assign start_conversion_cmd = r_reg.start;

endmodule // sensor_readout_device

// ==== test/readout_properties.sv ====
`timescale 1ns/10ps
// ============================================================================
// Link checker
module readout_properties (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Link signals.
  input wire logic scl,
  input wire logic sda_dev_oe,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [9:0] quiet_reg;

  // Counts cycles with both links idle, so a ready drop can be tied to traffic.
  always_ff @(posedge sys_clk) begin
    if (reset || !scl || !ss_n) begin
      quiet_reg <= 10'h000;
    end else if (quiet_reg != 10'h3FF) begin
      quiet_reg <= quiet_reg + 10'h001;
    end
  end

  a_miso_off_idle: assert property (ss_n [*5] |-> !miso_oe)
    else $error("Data-out driven while deselected");
  a_miso_on_select: assert property ($fell(ss_n) |-> ##[1:5] miso_oe)
    else $error("Data-out not enabled after select");
  a_miso_release: assert property ($rose(ss_n) |-> ##[1:5] !miso_oe)
    else $error("Data-out not released after deselect");
  a_first_status_bit: assert property ($fell(ss_n) |-> ##5 !miso_out)
    else $error("First status bit is one");
  a_sda_quiet_spi: assert property (!ss_n |-> !sda_dev_oe)
    else $error("Data line driven during a select");
  a_sda_scl_high: assert property (scl [*5] |-> $stable(sda_dev_oe))
    else $error("Data line changed while clock high");
  a_miso_frozen: assert property ((!ss_n && $stable(sclk)) [*8] |-> $stable(miso_out))
    else $error("Data-out changed without a clock edge");
  a_ready_hold: assert property ($fell(ready) |-> quiet_reg < 10'h014)
    else $error("Ready dropped with no transfer");

  // Main scenarios reached.
  c_spi_select: cover property ($fell(ss_n));
  c_ready_drop: cover property ($fell(ready));
  c_sda_drive: cover property ($rose(sda_dev_oe));
endmodule // readout_properties

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
// ============================================================================
// Bench top
module tb_top
  import readout_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic spi_sel = 1'b0;
  logic rise_sel = 1'b0;
  logic sleep_mode = 1'b0;
  logic meas_done = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] meas_res = 2'h3;
  logic [13:0] p_raw = 14'h0000;
  logic [13:0] t_raw = 14'h0000;
  cmd_type cmd_kind = CMD_FETCH;
  logic [2:0] byte_count = 3'h4;
  logic fetch_results_cmd, start_conversion_cmd, cmd_ready, rd_valid, done, addr_nack, ready_seen;
  logic [7:0] rd_data;
  logic [7:0] got [0:3];
  int error_cnt = 0;
  int cmp_count = 0;
  int nrx = 0;
  int fetch_cnt = 0;
  int start_cnt = 0;

  readout_if link_bus ();
  sensor_readout_device sensor_readout_device_inst (.sys_clk(sys_clk), .reset(reset), .link(link_bus.device_end),
    .spi_mode(spi_sel), .spi_sample_rising(rise_sel), .sleep_mode(sleep_mode), .meas_done(meas_done),
    .meas_res(meas_res), .pressure_raw(p_raw), .temperature_raw(t_raw), .fetch_results_cmd(fetch_results_cmd),
    .start_conversion_cmd(start_conversion_cmd));
  host_readout_master #(.I2C_Q_CYC(8), .SPI_H_CYC(8)) host_readout_master_inst (.sys_clk(sys_clk),
    .reset(reset), .link(link_bus.host_end), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .use_spi(spi_sel), .spi_sample_rising(rise_sel), .byte_count(byte_count), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .addr_nack(addr_nack), .ready_seen(ready_seen));
  readout_properties readout_properties_inst (.sys_clk(sys_clk), .reset(reset), .scl(link_bus.scl),
    .sda_dev_oe(link_bus.sda_dev_oe), .sclk(link_bus.sclk), .ss_n(link_bus.ss_n),
    .miso_out(link_bus.miso_out), .miso_oe(link_bus.miso_oe), .ready(link_bus.ready));

  // A 100 MHz system clock.
  always #5 sys_clk = ~sys_clk;

  // Collects received bytes and command pulses mid-cycle, where they are settled.
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1 && nrx < 4) begin
      got[nrx] = rd_data;
      nrx++;
    end
    if (fetch_results_cmd === 1'b1) fetch_cnt++;
    if (start_conversion_cmd === 1'b1) start_cnt++;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic end_sim;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Delivers one measurement result for one cycle.
  task automatic measure(input logic [1:0] res, input logic [13:0] p, input logic [13:0] t);
    @(posedge sys_clk);
    meas_res <= res;
    p_raw <= p;
    t_raw <= t;
    meas_done <= 1'b1;
    @(posedge sys_clk);
    meas_done <= 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  // Issues one host command and waits for its completion.
  task automatic run(input cmd_type k, input logic s, input logic r, input logic [2:0] n);
    int w;
    nrx = 0;
    @(posedge sys_clk);
    spi_sel <= s;
    rise_sel <= r;
    cmd_kind <= k;
    byte_count <= n;
    repeat (4) @(posedge sys_clk);
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 20000) begin
      @(negedge sys_clk);
      w++;
    end
    if (w >= 20000) error_cnt++;
    repeat (5) @(negedge sys_clk);
  endtask

  // Compares the received bytes with the packet built from status and results.
  task automatic chk_pkt(input logic [1:0] st, input logic [13:0] p, input logic [13:0] t, input int n);
    logic [31:0] e;
    logic [7:0] m;
    e = {st, p, t, 2'h0};
    `CHK("byte count", n, nrx)
    for (int i = 0; i < n; i++) begin
      m = (i == 3) ? 8'hFC : 8'hFF;
      `CHK("packet byte", e[31 - 8 * i -: 8] & m, got[i] & m)
    end
  endtask

  // Main sequence of transfers.
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK("ready", 1'b0, link_bus.ready)
    measure(2'h3, 14'h2ABC, 14'h1234);
    measure(2'h3, 14'h1F0F, 14'h0DEF);
    `CHK("ready seen", 1'b1, ready_seen)
    `CHK("ready", 1'b1, link_bus.ready)
    run(CMD_FETCH, 1'b0, 1'b0, 3'h4);
    chk_pkt(STATUS_FRESH, 14'h1F0F, 14'h0DEF, 4);
    `CHK("fetch count", 1, fetch_cnt)
    `CHK("addr nack", 1'b0, addr_nack)
    `CHK("ready", 1'b0, link_bus.ready)
    run(CMD_FETCH, 1'b0, 1'b0, 3'h2);
    chk_pkt(STATUS_STALE, 14'h1F0F, 14'h0DEF, 2);
    // A new result lands mid-transfer; the shifted packet must stay the old one.
    fork
      run(CMD_FETCH, 1'b1, 1'b0, 3'h4);
      begin
        repeat (300) @(posedge sys_clk);
        measure(2'h0, 14'h00A5, 14'h003C);
      end
    join
    chk_pkt(STATUS_STALE, 14'h1F0F, 14'h0DEF, 4);
    `CHK("ready", 1'b1, link_bus.ready)
    // The 8-bit result comes out shifted up by six.
    run(CMD_FETCH, 1'b1, 1'b1, 3'h3);
    chk_pkt(STATUS_FRESH, 14'h2940, 14'h0F00, 3);
    @(posedge sys_clk);
    sleep_mode <= 1'b1;
    run(CMD_START, 1'b0, 1'b0, 3'h1);
    `CHK("addr nack", 1'b0, addr_nack)
    run(CMD_START, 1'b1, 1'b0, 3'h1);
    `CHK("start count", 2, start_cnt)
    `CHK("fetch total", 4, fetch_cnt)
    `CHK("cmd ready", 1'b1, cmd_ready)
    end_sim;
  end

  // Cuts a hung run short.
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    end_sim;
  end
endmodule // tb_top
